// [rtl/twr_pkg.sv]
// Constants and state types for the tick counter, watchdog and reset-status block.
// Assumes a single 125 MHz clock that also serves as the instruction cycle.
package twr_pkg;
  localparam int unsigned CLK_PERIOD_NS  = 8;
  localparam int unsigned WDT_PERIOD_US  = 18000;
  localparam int unsigned WDT_CYCLES     = (WDT_PERIOD_US * 1000) / CLK_PERIOD_NS;
  localparam int unsigned WDT_CNT_W      = 22;

  localparam logic [7:0] ADDR_TICK_COUNT = 8'h01;
  localparam logic [7:0] ADDR_STATUS     = 8'h03;

  localparam logic [7:0] MODE_RESET      = 8'h3F;
  localparam logic [7:0] DIVIDER_RESET   = 8'hFF;
  localparam logic [7:0] TICK_POR_VALUE  = 8'h00;

  localparam int unsigned MODE_SRC_BIT   = 5;
  localparam int unsigned MODE_EDGE_BIT  = 4;
  localparam int unsigned MODE_ASSIGN_BIT = 3;
  localparam int unsigned MODE_RATIO_LSB = 0;

  localparam int unsigned ST_RSTF_BIT    = 7;
  localparam int unsigned ST_TO_BIT      = 4;
  localparam int unsigned ST_PD_BIT      = 3;

  typedef struct packed {
    logic [7:0] mode;
    logic [7:0] divider;
    logic [7:0] tick;
    logic       timeout_flag;
    logic       powerdown_flag;
    logic       wake_change_flag;
    logic [4:0] gen_bits;
    logic       asleep;
    logic       por_hold;
    logic       dev_rst;
    logic       overflow_flag;
    logic       wdt_timeout;
    logic [7:0] rd_data;
    logic [1:0] cnt_sync;
    logic       cnt_prev;
    logic [1:0] rpin_sync;
    logic [1:0] lvr_sync;
  } twr_top_s;

  typedef struct packed {
    logic [WDT_CNT_W-1:0] base_cnt;
    logic                 base_tick;
  } twr_wdt_s;
endpackage

// [rtl/twr_wdt_if.sv]
// Carrier between the control logic and the watchdog base counter.
// Assumes both ends run on ref_clk.
interface twr_wdt_if;
  logic clear;
  logic run;
  logic base_tick;
  modport ctrl (output clear, output run, input base_tick);
  modport wdt  (input clear, input run, output base_tick);
endinterface

// [rtl/twr_wdt.sv]
// Watchdog base counter: one pulse per nominal time-out period.
// Assumes the controller gives clear and run on the same clock.
module twr_wdt #(
  parameter int unsigned WDT_CYCLES = twr_pkg::WDT_CYCLES
) (
  input  wire logic ref_clk,
  input  wire logic sys_rst,
  twr_wdt_if.wdt    wif
);
  localparam logic [twr_pkg::WDT_CNT_W-1:0] LAST =
    twr_pkg::WDT_CNT_W'(WDT_CYCLES - 1);

  twr_pkg::twr_wdt_s s;
  twr_pkg::twr_wdt_s next_s;

  // Own time base, independent of the sleep state of the core
  always_comb
  begin
    next_s = s;
    next_s.base_tick = 1'b0;
    if (wif.clear || !wif.run)
    begin
      next_s.base_cnt = '0;
    end
    else if (s.base_cnt == LAST)
    begin
      next_s.base_cnt = '0;
      next_s.base_tick = 1'b1;
    end
    else
    begin
      next_s.base_cnt = s.base_cnt + 1'b1;
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      s <= '0;
    end
    else
    begin
      s <= next_s;
    end
  end

  assign wif.base_tick = s.base_tick;
endmodule // twr_wdt

// [rtl/twr_top.sv]
// Tick counter, shared divider, watchdog and reset / sleep status flags.
// Assumes a CPU core on ref_clk issuing one-cycle operation strobes, and
// raw pins (counting pin, reset pin, low-voltage detector) from outside.

// Overview of operation
// - Eight-bit counter; internal source advances each instruction cycle without divider.
// - External source advances counter on counting-pin edges, polarity from mode bit 4.
// - Edge select clear counts rising edges; set counts falling edges.
// - Wrap from FF to 00 sets the overflow flag.
// - Watchdog has its own time base and keeps counting through sleep.
// - Watchdog time-out resets the device and clears the time-out flag.
// - Watchdog period nominally 18 ms, lengthened by divider up to 1:128.
// - One divider serves watchdog when mode bit 3 set, else counter.
// - Three-bit ratio field selects the divider ratio.
// - Counter write clears the divider while the divider serves the counter.
// - Watchdog clear clears watchdog, and divider when assigned to watchdog.
// - After power-up the device stays in reset until reset pin is high.
// - Reset also from enabled reset pin low, watchdog time-out, low voltage.
// - Flag updates: power-on 1,1; sleep 1,0; watchdog clear 1,1; time-out 0,u.
// - Flags after reset follow the reset cause and sleep state.
// - Status bit 7 set only after wake by port input-change interrupt.
// - Sleep clears the watchdog; time-out or reset pin then wakes the device.
// - Any reset loads mode 3F and divider FF; counter kept on warm reset.
module twr_top #(
  parameter int unsigned WDT_CYCLES = twr_pkg::WDT_CYCLES
) (
  input  wire logic       ref_clk,
  input  wire logic       sys_rst,
  input  wire logic [7:0] reg_addr,
  input  wire logic       reg_wr,
  input  wire logic [7:0] reg_wr_data,
  output logic      [7:0] reg_rd_data,
  input  wire logic       mode_wr,
  input  wire logic [7:0] mode_wr_data,
  output logic      [7:0] tick_mode_control,
  output logic      [7:0] divider_count_value,
  input  wire logic       watchdog_clear_op,
  input  wire logic       sleep_op,
  input  wire logic       int_wake,
  input  wire logic       change_wake,
  input  wire logic       overflow_clr,
  output logic            overflow_flag,
  input  wire logic       external_count_pin,
  input  wire logic       reset_pin,
  input  wire logic       reset_pin_en,
  input  wire logic       wdt_en,
  input  wire logic       wdt_reset_en,
  input  wire logic       low_voltage,
  input  wire logic       low_voltage_en,
  output logic            wdt_timeout,
  output logic            asleep,
  output logic            dev_rst
);
  twr_pkg::twr_top_s s;
  twr_pkg::twr_top_s next_s;
  twr_wdt_if         wif ();

  twr_wdt #(
    .WDT_CYCLES (WDT_CYCLES)
  ) twr_wdt_i (
    .ref_clk (ref_clk),
    .sys_rst (sys_rst),
    .wif     (wif)
  );

  // True when the low n bits of a divider value are all zero
  function automatic logic low_bits_zero(input logic [7:0] val, input logic [3:0] n);
    logic [7:0] mask;
    mask = (n >= 4'd8) ? 8'hFF : 8'((9'h001 << n) - 9'h001);
    return (val & mask) == 8'h00;
  endfunction

  // Write strobe decode for one register address
  function automatic logic reg_hit(
    input logic       wr,
    input logic [7:0] addr,
    input logic [7:0] target
  );
    return wr && (addr == target);
  endfunction

  // Qualifying edge on the synchronised pin; falling when fall_sel is set
  function automatic logic pin_edge(
    input logic prev,
    input logic cur,
    input logic fall_sel
  );
    return fall_sel ? (prev && !cur) : (!prev && cur);
  endfunction

  // Status byte as the core sees it
  function automatic logic [7:0] status_image(
    input logic       wake_chg,
    input logic [4:0] gen,
    input logic       to_flag,
    input logic       pd_flag
  );
    return {wake_chg, gen[4:3], to_flag, pd_flag, gen[2:0]};
  endfunction

  // Read path; unmapped addresses read as zero
  function automatic logic [7:0] read_select(
    input logic [7:0] addr,
    input logic [7:0] tick,
    input logic [7:0] status
  );
    logic [7:0] val;
    if (addr == twr_pkg::ADDR_TICK_COUNT)
    begin
      val = tick;
    end
    else if (addr == twr_pkg::ADDR_STATUS)
    begin
      val = status;
    end
    else
    begin
      val = 8'h00;
    end
    return val;
  endfunction

  logic       assign_wdt;
  logic [2:0] ratio;
  logic       pin_reset;
  logic       wdt_reset;
  logic       lv_reset;
  logic       soft_reset;
  logic       count_event;
  logic       tick_inc;
  logic [7:0] div_inc;
  logic       wdt_expire;
  logic       wdt_clear_now;
  logic       tick_wr;
  logic       status_wr;
  logic       wrap_now;

  always_comb
  begin
    assign_wdt = s.mode[twr_pkg::MODE_ASSIGN_BIT];
    ratio      = s.mode[twr_pkg::MODE_RATIO_LSB +: 3];
    div_inc    = s.divider + 8'h01;
    pin_reset  = reset_pin_en && !s.rpin_sync[1];
    lv_reset   = low_voltage_en && s.lvr_sync[1];
    // Divider counts watchdog periods only while assigned to it
    wdt_expire = wif.base_tick && (!assign_wdt ||
                 low_bits_zero(div_inc, {1'b0, ratio}));
    wdt_reset  = wdt_expire && wdt_reset_en;
    soft_reset = !s.por_hold && (pin_reset || wdt_reset || lv_reset);
    wdt_clear_now = watchdog_clear_op || sleep_op;
    // One decode per target keeps write and divider clear in step
    tick_wr    = reg_hit(reg_wr, reg_addr, twr_pkg::ADDR_TICK_COUNT);
    status_wr  = reg_hit(reg_wr, reg_addr, twr_pkg::ADDR_STATUS);
    if (s.mode[twr_pkg::MODE_SRC_BIT])
    begin
      // Edge seen on the synchronised copy only
      count_event = pin_edge(s.cnt_prev, s.cnt_sync[1],
                             s.mode[twr_pkg::MODE_EDGE_BIT]);
    end
    else
    begin
      count_event = 1'b1;
    end
    // Core clock stops in sleep, so the counter does too
    count_event = count_event && !s.asleep && !s.dev_rst;
    tick_inc = count_event && (assign_wdt ||
               low_bits_zero(div_inc, {1'b0, ratio} + 4'd1));
    // Wrap only from a real count, never from a write
    wrap_now = tick_inc && (s.tick == 8'hFF) && !tick_wr;
  end

  assign wif.clear = wdt_clear_now || soft_reset || s.dev_rst;
  assign wif.run   = wdt_en;

  always_comb
  begin
    next_s = s;
    next_s.rpin_sync = {s.rpin_sync[0], reset_pin};
    next_s.lvr_sync  = {s.lvr_sync[0], low_voltage};
    next_s.cnt_sync  = {s.cnt_sync[0], external_count_pin};
    next_s.cnt_prev  = s.cnt_sync[1];
    next_s.wdt_timeout = wdt_expire;

    // Divider: shared between counter and watchdog
    if (!assign_wdt && count_event)
    begin
      next_s.divider = div_inc;
    end
    else if (assign_wdt && wif.base_tick)
    begin
      next_s.divider = div_inc;
    end
    if (!assign_wdt && tick_wr)
    begin
      next_s.divider = 8'h00;
    end
    if (assign_wdt && watchdog_clear_op)
    begin
      next_s.divider = 8'h00;
    end

    // Counter
    if (tick_wr)
    begin
      next_s.tick = reg_wr_data;
    end
    else if (tick_inc)
    begin
      next_s.tick = s.tick + 8'h01;
    end

    // Set wins over a simultaneous clear
    if (overflow_clr)
    begin
      next_s.overflow_flag = 1'b0;
    end
    if (wrap_now)
    begin
      next_s.overflow_flag = 1'b1;
    end

    // Mode register; order is left to software
    if (mode_wr)
    begin
      next_s.mode = mode_wr_data;
    end

    // Status register, general bits only
    if (status_wr)
    begin
      next_s.gen_bits = {reg_wr_data[6:5], reg_wr_data[2:0]};
    end
    if (watchdog_clear_op)
    begin
      next_s.timeout_flag   = 1'b1;
      next_s.powerdown_flag = 1'b1;
    end
    if (sleep_op && !s.dev_rst)
    begin
      next_s.asleep         = 1'b1;
      next_s.timeout_flag   = 1'b1;
      next_s.powerdown_flag = 1'b0;
    end
    if (s.asleep && (int_wake || change_wake))
    begin
      next_s.asleep           = 1'b0;
      next_s.wake_change_flag = change_wake;
    end

    // Warm resets: flags follow the cause, counter kept
    if (soft_reset)
    begin
      next_s.mode             = twr_pkg::MODE_RESET;
      next_s.divider          = twr_pkg::DIVIDER_RESET;
      next_s.asleep           = 1'b0;
      next_s.wake_change_flag = 1'b0;
      next_s.overflow_flag    = 1'b0;
      next_s.timeout_flag     = s.timeout_flag;
      next_s.powerdown_flag   = s.powerdown_flag;
      if (wdt_reset)
      begin
        next_s.timeout_flag = 1'b0;
      end
    end

    // Power-up hold until the reset pin reads high
    if (s.por_hold)
    begin
      next_s.mode     = twr_pkg::MODE_RESET;
      next_s.divider  = twr_pkg::DIVIDER_RESET;
      next_s.tick     = twr_pkg::TICK_POR_VALUE;
      next_s.por_hold = !s.rpin_sync[1];
    end
    next_s.dev_rst = next_s.por_hold || soft_reset;

    next_s.rd_data = read_select(reg_addr, next_s.tick,
                                 status_image(next_s.wake_change_flag, next_s.gen_bits,
                                              next_s.timeout_flag,
                                              next_s.powerdown_flag));
  end

  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      s                  <= '0;
      s.mode             <= twr_pkg::MODE_RESET;
      s.divider          <= twr_pkg::DIVIDER_RESET;
      s.tick             <= twr_pkg::TICK_POR_VALUE;
      s.timeout_flag     <= 1'b1;
      s.powerdown_flag   <= 1'b1;
      s.por_hold         <= 1'b1;
      s.dev_rst          <= 1'b1;
    end
    else
    begin
      s <= next_s;
    end
  end

  assign reg_rd_data         = s.rd_data;
  assign tick_mode_control   = s.mode;
  assign divider_count_value = s.divider;
  assign overflow_flag       = s.overflow_flag;
  assign wdt_timeout         = s.wdt_timeout;
  assign asleep              = s.asleep;
  assign dev_rst             = s.dev_rst;
endmodule // twr_top

// [dv/twr_top_props.sv]
// Port-level assertions for the tick counter, watchdog and status block.
// Assumes it is bound into twr_top and sees only that module's ports.
module twr_top_props #(
  parameter int unsigned WDT_CYCLES = 20
) (
  input wire logic       ref_clk,
  input wire logic       sys_rst,
  input wire logic       reg_wr,
  input wire logic       mode_wr,
  input wire logic       watchdog_clear_op,
  input wire logic       sleep_op,
  input wire logic       overflow_flag,
  input wire logic       reset_pin,
  input wire logic       reset_pin_en,
  input wire logic       wdt_reset_en,
  input wire logic       wdt_timeout,
  input wire logic       asleep,
  input wire logic       dev_rst,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_rd_data,
  input wire logic [7:0] mode_wr_data,
  input wire logic [7:0] tick_mode_control,
  input wire logic [7:0] divider_count_value,
  input wire logic       wdt_en
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  AST_WDT_RST: assert property (wdt_timeout && wdt_reset_en |-> ##[0:1] dev_rst)
    else $error("expiry without device reset");
  AST_RST_LOAD: assert property ($fell(dev_rst) |-> tick_mode_control == 8'h3F
    && divider_count_value == 8'hFF) else $error("reset values not loaded");
  AST_PIN_RST: assert property ((reset_pin_en && !reset_pin) [*4] |-> dev_rst)
    else $error("reset pin low without reset");
  AST_SLEEP: assert property (sleep_op && !dev_rst && !asleep |=> asleep)
    else $error("sleep not entered");
  AST_MODE_WR: assert property (mode_wr && !dev_rst && !wdt_en
    |=> tick_mode_control == $past(mode_wr_data)) else $error("mode write lost");
  AST_WR_CLR_DIV: assert property (reg_wr && reg_addr == 8'h01 && !mode_wr &&
    !tick_mode_control[3] && !dev_rst |=> divider_count_value == 8'h00)
    else $error("counter write kept divider");
  AST_WATCHDOG_CLEAR_OP_DIV: assert property (watchdog_clear_op && tick_mode_control[3] &&
    !mode_wr && !dev_rst |=> divider_count_value == 8'h00) else $error("clear kept divider");
  AST_DIV_SLEEP: assert property (asleep && $past(asleep) && !tick_mode_control[3]
    |-> $stable(divider_count_value)) else $error("divider ran in sleep");
  AST_OVF: assert property (reg_addr == 8'h01 && $past(reg_addr) == 8'h01 &&
    !$past(reg_wr) && $past(reg_rd_data) == 8'hFF && reg_rd_data == 8'h00
    |-> ##[0:1] overflow_flag) else $error("wrap without overflow flag");
  cover property (sleep_op ##1 asleep);
  cover property (wdt_timeout && asleep);
  cover property ($rose(overflow_flag));
endmodule // twr_top_props

// [dv/tb_twr_top.sv]
// Self-checking bench for twr_top: reads, counting, watchdog, sleep, resets.
// Assumes the rtl package, interface and modules are compiled first.
module tb_twr_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int unsigned WDT_CYCLES = 20;
  logic ref_clk, sys_rst, reg_wr, mode_wr, watchdog_clear_op, sleep_op, int_wake;
  logic change_wake, overflow_clr, external_count_pin, reset_pin, reset_pin_en;
  logic wdt_en, wdt_reset_en, low_voltage, low_voltage_en, rd_chk, rd_pend;
  logic overflow_flag, wdt_timeout, asleep, dev_rst;
  logic [7:0] reg_addr, reg_wr_data, reg_rd_data, mode_wr_data, r;
  logic [7:0] tick_mode_control, divider_count_value;
  logic [7:0] exp_q[$];
  int err_total, checks, n;
  twr_top #(
    .WDT_CYCLES (WDT_CYCLES)
  ) twr_top_i (
    .ref_clk             (ref_clk),
    .sys_rst             (sys_rst),
    .reg_addr            (reg_addr),
    .reg_wr              (reg_wr),
    .reg_wr_data         (reg_wr_data),
    .reg_rd_data         (reg_rd_data),
    .mode_wr             (mode_wr),
    .mode_wr_data        (mode_wr_data),
    .tick_mode_control   (tick_mode_control),
    .divider_count_value (divider_count_value),
    .watchdog_clear_op   (watchdog_clear_op),
    .sleep_op            (sleep_op),
    .int_wake            (int_wake),
    .change_wake         (change_wake),
    .overflow_clr        (overflow_clr),
    .overflow_flag       (overflow_flag),
    .external_count_pin  (external_count_pin),
    .reset_pin           (reset_pin),
    .reset_pin_en        (reset_pin_en),
    .wdt_en              (wdt_en),
    .wdt_reset_en        (wdt_reset_en),
    .low_voltage         (low_voltage),
    .low_voltage_en      (low_voltage_en),
    .wdt_timeout         (wdt_timeout),
    .asleep              (asleep),
    .dev_rst             (dev_rst)
  );
  task automatic chk(string what, logic [7:0] exp, logic [7:0] got);
    checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic cyc(int k);
    repeat (k) @(negedge ref_clk);
  endtask
  task automatic pulse(ref logic s);
    @(negedge ref_clk);
    s = 1'b1;
    @(negedge ref_clk);
    s = 1'b0;
  endtask
  task automatic wr(logic [7:0] a, logic [7:0] d);
    reg_wr_data = d;
    reg_addr = a;
    pulse(reg_wr);
  endtask
  task automatic md(logic [7:0] d);
    mode_wr_data = d;
    pulse(mode_wr);
  endtask
  // Note taken here, compared by the monitor once the data lands
  task automatic rd(logic [7:0] a, logic [7:0] e);
    @(negedge ref_clk);
    reg_addr = a;
    exp_q.push_back(e);
    rd_chk = 1'b1;
    @(negedge ref_clk);
    rd_chk = 1'b0;
  endtask
  task automatic wait_v(ref logic s, input logic v, output int c);
    c = 0;
    while (s !== v && c < 200)
    begin
      @(negedge ref_clk);
      c++;
    end
    // A level never reached counts against the run
    chk("wait level", 8'(v), 8'(s));
  endtask
  // Each toggle is held long enough to pass the pin synchroniser
  task automatic edges(int k);
    repeat (k)
    begin
      external_count_pin = ~external_count_pin;
      cyc(4);
    end
  endtask
  always @(posedge ref_clk) rd_pend <= rd_chk;
  always @(negedge ref_clk)
    if (rd_pend === 1'b1)
      chk("reg_rd_data", exp_q.pop_front(), reg_rd_data);
  initial
  begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end
  initial
  begin
    #100us;
    err_total++;
    tally_and_finish();
  end
  initial
  begin
    {reg_wr, mode_wr, watchdog_clear_op, sleep_op, int_wake, change_wake} = '0;
    {overflow_clr, external_count_pin, wdt_en, low_voltage, rd_chk, reset_pin} = '0;
    {reg_addr, reg_wr_data, mode_wr_data} = '0;
    {sys_rst, reset_pin_en, wdt_reset_en, low_voltage_en} = '1;
    void'($urandom(32'h8ea19a3b));
    cyc(6);
    sys_rst = 1'b0;
    cyc(10);
    chk("dev_rst", 8'h01, dev_rst);
    reset_pin = 1'b1;
    wait_v(dev_rst, 1'b0, n);
    chk("mode", twr_pkg::MODE_RESET, tick_mode_control);
    chk("divider", twr_pkg::DIVIDER_RESET, divider_count_value);
    rd(twr_pkg::ADDR_STATUS, 8'h18);
    wr(twr_pkg::ADDR_STATUS, 8'hFF);
    rd(twr_pkg::ADDR_STATUS, 8'h7F);
    wr(twr_pkg::ADDR_STATUS, 8'h00);
    rd(8'h05, 8'h00);
    $display("test reset done");
    md(8'h28);
    r = 8'($urandom);
    n = 1 + $urandom_range(7);
    wr(twr_pkg::ADDR_TICK_COUNT, r);
    edges(2 * n);
    rd(twr_pkg::ADDR_TICK_COUNT, r + 8'(n));
    md(8'h38);
    edges(2 * n + 1);
    rd(twr_pkg::ADDR_TICK_COUNT, r + 8'(2 * n));
    wr(twr_pkg::ADDR_TICK_COUNT, 8'hFE);
    edges(4);
    chk("overflow", 8'h01, overflow_flag);
    pulse(overflow_clr);
    chk("overflow", 8'h00, overflow_flag);
    $display("test pin count done");
    md(8'h08);
    wr(twr_pkg::ADDR_TICK_COUNT, 8'h00);
    cyc(10);
    rd(twr_pkg::ADDR_TICK_COUNT, 8'h0C);
    pulse(watchdog_clear_op);
    md(8'h02);
    wr(twr_pkg::ADDR_TICK_COUNT, 8'h00);
    chk("divider", 8'h00, divider_count_value);
    cyc(34);
    rd(twr_pkg::ADDR_TICK_COUNT, 8'h04);
    $display("test internal count done");
    pulse(watchdog_clear_op);
    wr(twr_pkg::ADDR_TICK_COUNT, 8'h00);
    md(8'h08);
    wdt_en = 1'b1;
    pulse(watchdog_clear_op);
    chk("divider", 8'h00, divider_count_value);
    wait_v(wdt_timeout, 1'b1, n);
    chk("wdt period", 8'h01, 8'(n > 15 && n < 26));
    wait_v(dev_rst, 1'b0, n);
    wdt_en = 1'b0;
    chk("mode", twr_pkg::MODE_RESET, tick_mode_control);
    rd(twr_pkg::ADDR_STATUS, 8'h08);
    $display("test watchdog done");
    md(8'h20);
    pulse(watchdog_clear_op);
    pulse(sleep_op);
    rd(twr_pkg::ADDR_STATUS, 8'h10);
    pulse(change_wake);
    chk("asleep", 8'h00, asleep);
    rd(twr_pkg::ADDR_STATUS, 8'h90);
    pulse(sleep_op);
    pulse(int_wake);
    rd(twr_pkg::ADDR_STATUS, 8'h10);
    pulse(watchdog_clear_op);
    wr(twr_pkg::ADDR_TICK_COUNT, 8'h00);
    md(8'h09);
    wdt_en = 1'b1;
    pulse(sleep_op);
    wait_v(wdt_timeout, 1'b1, n);
    chk("wdt period", 8'h01, 8'(n > 2 * WDT_CYCLES - 5 && n < 2 * WDT_CYCLES + 6));
    wait_v(dev_rst, 1'b0, n);
    wdt_en = 1'b0;
    chk("asleep", 8'h00, asleep);
    rd(twr_pkg::ADDR_STATUS, 8'h00);
    $display("test sleep done");
    wr(twr_pkg::ADDR_TICK_COUNT, 8'hA5);
    pulse(sleep_op);
    reset_pin = 1'b0;
    cyc(8);
    chk("dev_rst", 8'h01, dev_rst);
    reset_pin = 1'b1;
    wait_v(dev_rst, 1'b0, n);
    rd(twr_pkg::ADDR_STATUS, 8'h10);
    rd(twr_pkg::ADDR_TICK_COUNT, 8'hA5);
    low_voltage = 1'b1;
    cyc(8);
    chk("dev_rst", 8'h01, dev_rst);
    low_voltage = 1'b0;
    wait_v(dev_rst, 1'b0, n);
    rd(twr_pkg::ADDR_STATUS, 8'h10);
    $display("test pin reset done");
    tally_and_finish();
  end
endmodule // tb_twr_top
bind twr_top twr_top_props #(
  .WDT_CYCLES (WDT_CYCLES)
) twr_top_props_i (
  .ref_clk             (ref_clk),
  .sys_rst             (sys_rst),
  .reg_wr              (reg_wr),
  .mode_wr             (mode_wr),
  .watchdog_clear_op   (watchdog_clear_op),
  .sleep_op            (sleep_op),
  .overflow_flag       (overflow_flag),
  .reset_pin           (reset_pin),
  .reset_pin_en        (reset_pin_en),
  .wdt_reset_en        (wdt_reset_en),
  .wdt_timeout         (wdt_timeout),
  .asleep              (asleep),
  .dev_rst             (dev_rst),
  .reg_addr            (reg_addr),
  .reg_rd_data         (reg_rd_data),
  .mode_wr_data        (mode_wr_data),
  .tick_mode_control   (tick_mode_control),
  .divider_count_value (divider_count_value),
  .wdt_en              (wdt_en)
);
